// file: preset_recall.sv
// The address map and register access over Avalon-MM were decided locally.
`default_nettype none

module preset_recall
(
    input  wire logic                                   clk,
    input  wire logic                                   nrst,
    input  wire logic [preset_recall_pkg::ADDR_W-1:0]   avs_address,
    input  wire logic                                   avs_read,
    input  wire logic                                   avs_write,
    input  wire logic [31:0]                            avs_writedata,
    input  wire logic [3:0]                             avs_byteenable,
    output logic      [31:0]                            avs_readdata,
    output logic                                        avs_waitrequest,
    input  wire logic [preset_recall_pkg::NUM_INPUTS-1:0] input_pin,
    output logic                                        input_one_level_report,
    output logic                                        input_two_level_report,
    output logic                                        input_three_level_report,
    output logic      [preset_recall_pkg::CFG_W-1:0]    active_config,
    output logic                                        irq
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [preset_recall_pkg::NUM_INPUTS-1:0] sync1;
        logic [preset_recall_pkg::NUM_INPUTS-1:0] sync2;
        logic [preset_recall_pkg::NUM_INPUTS-1:0] sync3;
        logic [preset_recall_pkg::NUM_INPUTS-1:0] level;
        logic [preset_recall_pkg::NUM_INPUTS-1:0] action;
        logic [preset_recall_pkg::NUM_INPUTS-1:0] pend;
        logic [preset_recall_pkg::CFG_W-1:0]      cfg;
        logic [preset_recall_pkg::NUM_SLOTS-1:0]  valid;
        logic [preset_recall_pkg::IRQ_W-1:0]      status;
        logic [preset_recall_pkg::IRQ_W-1:0]      mask;
        logic [preset_recall_pkg::SLOT_W-1:0]     slot;
        preset_recall_pkg::engine_state_t         st;
        logic                                     waitrequest;
        logic [31:0]                              rdata;
        logic                                     irq;
    } top_state_t;

    top_state_t q;
    top_state_t d;

    preset_mem_if mem ();

    preset_store u_store
    (
        .clk  (clk),
        .nrst (nrst),
        .mem  (mem.store)
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // Merge write data into an old word under the byte enables.
    function automatic logic [31:0] be_merge
    (
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0]  be
    );
        logic [31:0] r;
        r = old_val;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
            begin
                r[b*8 +: 8] = new_val[b*8 +: 8];
            end
        end
        return r;
    endfunction : be_merge

    // True when a slot number names one of the five presets.
    function automatic logic slot_ok(input logic [preset_recall_pkg::SLOT_W-1:0] s);
        return (s >= preset_recall_pkg::SLOT_FIRST) &&
               (s < preset_recall_pkg::SLOT_FIRST + preset_recall_pkg::SLOT_W'(preset_recall_pkg::NUM_SLOTS));
    endfunction : slot_ok

    // Storage index of a slot number.
    function automatic logic [preset_recall_pkg::SLOT_W-1:0] slot_idx
    (
        input logic [preset_recall_pkg::SLOT_W-1:0] s
    );
        return s - preset_recall_pkg::SLOT_FIRST;
    endfunction : slot_idx

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    logic [preset_recall_pkg::NUM_INPUTS-1:0] fall;
    logic [preset_recall_pkg::NUM_INPUTS-1:0] fire;
    logic [preset_recall_pkg::NUM_INPUTS-1:0] pend_clr;
    logic [preset_recall_pkg::IRQ_W-1:0]      irq_set;
    logic [preset_recall_pkg::IRQ_W-1:0]      irq_clr;
    logic [preset_recall_pkg::SLOT_W-1:0]     req_slot;
    logic [preset_recall_pkg::SLOT_W-1:0]     cmd_slot;
    logic                                     req_go;
    logic                                     accept;
    logic                                     wr_go;
    logic                                     picked;

    always_comb
    begin
        d         = q;
        fall      = '0;
        pend_clr  = '0;
        irq_set   = '0;
        irq_clr   = '0;
        req_slot  = '0;
        req_go    = 1'b0;
        picked    = 1'b0;
        mem.we    = 1'b0;
        mem.waddr = '0;
        mem.wdata = q.cfg;
        mem.re    = 1'b0;
        mem.raddr = slot_idx(q.slot);
        cmd_slot  = avs_writedata[preset_recall_pkg::CMD_SLOT_LSB +: preset_recall_pkg::SLOT_W];

        // Three-stage input synchroniser; a level counts once stages two and three agree.
        d.sync1 = input_pin;
        d.sync2 = q.sync1;
        d.sync3 = q.sync2;
        for (int i = 0; i < preset_recall_pkg::NUM_INPUTS; i++)
        begin
            if (q.sync2[i] == q.sync3[i])
            begin
                d.level[i] = q.sync3[i];
                fall[i]    = q.level[i] && !q.sync3[i];
            end
        end

        // Only armed inputs raise events and queue recalls.
        fire    = fall & q.action;
        irq_set[preset_recall_pkg::NUM_INPUTS-1:0] = fire;

        // Bus slave: one wait cycle, writes held off while the engine is busy.
        accept = q.waitrequest &&
                 (avs_read || (avs_write && (q.st == preset_recall_pkg::ST_IDLE)));
        wr_go  = avs_write && !q.waitrequest;
        d.waitrequest = !accept;
        if (accept && avs_read)
        begin
            case (avs_address)
                preset_recall_pkg::OFF_ACTION: d.rdata = 32'(q.action);
                preset_recall_pkg::OFF_LEVEL:  d.rdata = 32'(q.level);
                preset_recall_pkg::OFF_CONFIG: d.rdata = q.cfg;
                preset_recall_pkg::OFF_VALID:  d.rdata = 32'(q.valid);
                preset_recall_pkg::OFF_STATUS: d.rdata = 32'(q.status);
                preset_recall_pkg::OFF_MASK:   d.rdata = 32'(q.mask);
                default:                       d.rdata = 32'h0000_0000;
            endcase
        end

        // Register writes; the command register is handled by the engine below.
        if (wr_go)
        begin
            case (avs_address)
                preset_recall_pkg::OFF_ACTION:
                    d.action = preset_recall_pkg::NUM_INPUTS'(
                        be_merge(32'(q.action), avs_writedata, avs_byteenable));
                preset_recall_pkg::OFF_CONFIG:
                    d.cfg = be_merge(q.cfg, avs_writedata, avs_byteenable);
                preset_recall_pkg::OFF_STATUS:
                    irq_clr = preset_recall_pkg::IRQ_W'(
                        be_merge(32'h0000_0000, avs_writedata, avs_byteenable));
                preset_recall_pkg::OFF_MASK:
                    d.mask = preset_recall_pkg::IRQ_W'(
                        be_merge(32'(q.mask), avs_writedata, avs_byteenable));
                default:
                    d.mask = q.mask;
            endcase
        end

        // Recall engine.
        case (q.st)
            preset_recall_pkg::ST_IDLE:
            begin
                if (wr_go && (avs_address == preset_recall_pkg::OFF_CMD))
                begin
                    if (avs_writedata[preset_recall_pkg::CMD_SAVE_BIT])
                    begin
                        if (slot_ok(cmd_slot))
                        begin
                            mem.we   = 1'b1;
                            mem.waddr = slot_idx(cmd_slot);
                            d.valid[slot_idx(cmd_slot)] = 1'b1;
                        end
                    end
                    else if (avs_writedata[preset_recall_pkg::CMD_RECALL_BIT])
                    begin
                        req_go   = 1'b1;
                        req_slot = cmd_slot;
                    end
                end
                else if (!avs_write)
                begin
                    // Lowest pending input first; input n recalls slot n.
                    for (int i = 0; i < preset_recall_pkg::NUM_INPUTS; i++)
                    begin
                        if (q.pend[i] && !picked)
                        begin
                            picked      = 1'b1;
                            pend_clr[i] = 1'b1;
                            req_go      = 1'b1;
                            req_slot    = preset_recall_pkg::SLOT_FIRST +
                                          preset_recall_pkg::SLOT_W'(i);
                        end
                    end
                end
                if (req_go)
                begin
                    if (slot_ok(req_slot) && q.valid[slot_idx(req_slot)])
                    begin
                        d.slot = req_slot;
                        d.st   = preset_recall_pkg::ST_FETCH;
                    end
                    else
                    begin
                        irq_set[preset_recall_pkg::IRQ_EMPTY_BIT] = 1'b1;
                    end
                end
            end
            preset_recall_pkg::ST_FETCH:
            begin
                mem.re = 1'b1;
                d.st   = preset_recall_pkg::ST_LOAD;
            end
            preset_recall_pkg::ST_LOAD:
            begin
                d.cfg = mem.rdata;
                irq_set[preset_recall_pkg::IRQ_DONE_BIT] = 1'b1;
                d.st  = preset_recall_pkg::ST_IDLE;
            end
            default:
            begin
                d.st = preset_recall_pkg::ST_IDLE;
            end
        endcase

        // Pending recalls and sticky status: a new event wins over its clear.
        d.pend   = (q.pend & ~pend_clr) | fire;
        d.status = (q.status & ~irq_clr) | irq_set;
        d.irq    = |(d.status & d.mask);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------

    // All state in one register, constant values under reset.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            q             <= '0;
            q.sync1       <= preset_recall_pkg::LEVEL_RST;
            q.sync2       <= preset_recall_pkg::LEVEL_RST;
            q.sync3       <= preset_recall_pkg::LEVEL_RST;
            q.level       <= preset_recall_pkg::LEVEL_RST;
            q.action      <= preset_recall_pkg::ACTION_RST;
            q.cfg         <= preset_recall_pkg::CONFIG_RST;
            q.st          <= preset_recall_pkg::ST_IDLE;
            q.waitrequest <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, each straight from the state register
    // ----------------------------------------------------------------
    assign avs_readdata             = q.rdata;
    assign avs_waitrequest          = q.waitrequest;
    assign input_one_level_report   = q.level[0];
    assign input_two_level_report   = q.level[1];
    assign input_three_level_report = q.level[2];
    assign active_config            = q.cfg;
    assign irq                      = q.irq;

endmodule : preset_recall

`default_nettype wire

// file: preset_recall_pkg.sv
`default_nettype none

package preset_recall_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int unsigned NUM_INPUTS = 3;
    localparam int unsigned NUM_SLOTS  = 5;
    localparam int unsigned CFG_W      = 32;
    localparam int unsigned SLOT_W     = 3;
    localparam int unsigned IRQ_W      = 5;
    localparam int unsigned ADDR_W     = 5;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_ACTION = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_LEVEL  = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_CONFIG = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_CMD    = 5'h0c;
    localparam logic [ADDR_W-1:0] OFF_VALID  = 5'h10;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h14;
    localparam logic [ADDR_W-1:0] OFF_MASK   = 5'h18;

    // ----------------------------------------------------------------
    // Command register fields
    // ----------------------------------------------------------------
    localparam int unsigned CMD_SLOT_LSB   = 0;
    localparam int unsigned CMD_SAVE_BIT   = 8;
    localparam int unsigned CMD_RECALL_BIT = 9;

    // ----------------------------------------------------------------
    // Interrupt status bit positions
    // ----------------------------------------------------------------
    localparam int unsigned IRQ_DONE_BIT  = 3;
    localparam int unsigned IRQ_EMPTY_BIT = 4;

    // ----------------------------------------------------------------
    // Reset values and first slot number
    // ----------------------------------------------------------------
    localparam logic [NUM_INPUTS-1:0] LEVEL_RST  = 3'h7;
    localparam logic [NUM_INPUTS-1:0] ACTION_RST = 3'h0;
    localparam logic [CFG_W-1:0]      CONFIG_RST = 32'h0000_0000;
    localparam logic [SLOT_W-1:0]     SLOT_FIRST = 3'h1;

    // ----------------------------------------------------------------
    // Recall engine states, Gray coded from idle through fetch to load; the return from load to idle flips both bits
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_FETCH = 2'h1,
        ST_LOAD  = 2'h3
    } engine_state_t;

endpackage : preset_recall_pkg

`default_nettype wire

// file: preset_mem_if.sv
`default_nettype none

// Port between the recall engine and the preset store.
interface preset_mem_if;
    logic                                       we;
    logic [preset_recall_pkg::SLOT_W-1:0]       waddr;
    logic [preset_recall_pkg::CFG_W-1:0]        wdata;
    logic                                       re;
    logic [preset_recall_pkg::SLOT_W-1:0]       raddr;
    logic [preset_recall_pkg::CFG_W-1:0]        rdata;

    modport ctrl (output we, output waddr, output wdata, output re, output raddr, input rdata);
    modport store (input we, input waddr, input wdata, input re, input raddr, output rdata);
endinterface : preset_mem_if

`default_nettype wire

// file: preset_store.sv
`default_nettype none

module preset_store
(
    input  wire logic   clk,
    input  wire logic   nrst,
    preset_mem_if.store mem
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [preset_recall_pkg::NUM_SLOTS-1:0][preset_recall_pkg::CFG_W-1:0] slot;
        logic [preset_recall_pkg::CFG_W-1:0]                                  rdata;
    } store_state_t;

    store_state_t q;
    store_state_t d;

    // Five whole-configuration words; read data leave through a register.
    always_comb
    begin
        d = q;
        if (mem.we && (mem.waddr < preset_recall_pkg::NUM_SLOTS))
        begin
            d.slot[mem.waddr] = mem.wdata;
        end
        if (mem.re && (mem.raddr < preset_recall_pkg::NUM_SLOTS))
        begin
            d.rdata = q.slot[mem.raddr];
        end
    end

    // Register the whole state.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign mem.rdata = q.rdata;

endmodule : preset_store

`default_nettype wire

// file: preset_recall_properties.sv
`default_nettype none

// ----------------------------------------
// Port-level properties of the preset recall block
// ----------------------------------------
module preset_recall_properties
(
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [2:0]  input_pin,
    input wire logic        input_one_level_report,
    input wire logic        input_two_level_report,
    input wire logic        input_three_level_report,
    input wire logic [31:0] active_config,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] level_vec;
    logic [4:0] quiet_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // The three level reports as one vector, input one in bit 0.
    assign level_vec = {input_three_level_report, input_two_level_report, input_one_level_report};

    // Counts cycles with every contact open and no write on the bus.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            quiet_q <= 5'h0;
        else if (!(&input_pin) || avs_write)
            quiet_q <= 5'h0;
        else if (quiet_q != 5'h1f)
            quiet_q <= quiet_q + 5'h1;
    end

    level_track_a : assert property (
        $stable(input_pin) [*6] |-> level_vec == input_pin)
        else $error("Level report differs from a steady pin.");
    level_read_a : assert property (
        avs_read && !avs_waitrequest && avs_address == preset_recall_pkg::OFF_LEVEL && $stable(level_vec)
        |-> avs_readdata == {29'h0, level_vec})
        else $error("Level register read differs from the level reports.");
    valid_width_a : assert property (
        avs_read && !avs_waitrequest && avs_address == preset_recall_pkg::OFF_VALID |-> avs_readdata[31:5] == 27'h0)
        else $error("Valid register shows more than five slots.");
    read_answer_a : assert property (
        $rose(avs_read) |=> !avs_waitrequest)
        else $error("Read not answered one cycle after it was taken.");
    write_bound_a : assert property (
        $rose(avs_write) |-> ##[1:12] !avs_waitrequest)
        else $error("Write not answered in time.");
    wait_pulse_a : assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("Waitrequest low for more than one cycle.");
    ack_cause_a : assert property (
        !avs_waitrequest |-> $past(avs_read) || $past(avs_write))
        else $error("Access answered without a request.");
    quiet_config_a : assert property (
        quiet_q >= 5'h14 |-> $stable(active_config))
        else $error("Configuration changed with contacts open and no write.");
endmodule : preset_recall_properties

`default_nettype wire

// file: contact_model.sv
`default_nettype none

// ----------------------------------------
// External contact closures on the three inputs
// ----------------------------------------
module contact_model
(
    input  wire logic clk,
    output logic [2:0] pin
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] closed_q = 3'h0;

    // An open contact leaves the pulled-up line high.
    assign pin = ~closed_q;

    // Closes or opens one contact just after an edge, then holds it for the given cycles.
    task automatic set_contact(input int idx, input logic close, input int hold);
        @(posedge clk);
        closed_q[idx] <= close;
        repeat (hold) @(posedge clk);
    endtask : set_contact
endmodule : contact_model

`default_nettype wire

// file: edge_triggered_preset_recall_tb_top.sv
`default_nettype none

module edge_triggered_preset_recall_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Signals and bench state
    // ----------------------------------------
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [4:0]  avs_address = 5'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [2:0]  input_pin;
    logic        lvl1, lvl2, lvl3;
    logic [31:0] active_config;
    logic        irq;
    logic [31:0] cfg_a [1:5];
    logic [31:0] rd;
    logic [31:0] keep;
    int          fail_count = 0;
    int          comparisons = 0;

    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    preset_recall u_dut (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .input_pin(input_pin),
        .input_one_level_report(lvl1), .input_two_level_report(lvl2), .input_three_level_report(lvl3),
        .active_config(active_config), .irq(irq));

    contact_model u_contacts (.clk(clk), .pin(input_pin));

    // ----------------------------------------
    // Checking, bus and expectation helpers
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_word

    // One bus access held until waitrequest is seen low, bounded by a timeout.
    task automatic bus(input logic wr_en, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr_en;
        avs_read <= !wr_en;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 40);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (avs_waitrequest !== 1'b0)
        begin
            fail_count++;
            tally_and_finish();
        end
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check_word(rd, exp);
    endtask : rd_chk

    // Waits a bounded time for the configuration to reach a value, then compares.
    task automatic wait_cfg(input logic [31:0] exp);
        for (int n = 0; n < 40 && active_config !== exp; n++)
            @(posedge clk);
        check_word(active_config, exp);
    endtask : wait_cfg

    function automatic logic [31:0] slot_cmd(input int s, input logic save);
        return (32'h1 << (save ? preset_recall_pkg::CMD_SAVE_BIT : preset_recall_pkg::CMD_RECALL_BIT)) | 32'(s);
    endfunction : slot_cmd

    function automatic logic [31:0] bit_of(input int b);
        return 32'h1 << b;
    endfunction : bit_of

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        void'($urandom(32'h5b21));
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        check_word({28'h0, lvl3, lvl2, lvl1, irq}, 32'he);
        check_word(active_config, preset_recall_pkg::CONFIG_RST);
        rd_chk(preset_recall_pkg::OFF_ACTION, 32'h0);
        rd_chk(5'h1c, 32'h0);
        wr(5'h1c, 32'hffff_ffff);
        rd_chk(preset_recall_pkg::OFF_MASK, 32'h0);
        $display("Test reset done");
        keep = $urandom();
        wr(preset_recall_pkg::OFF_MASK, 32'h1f);
        wr(preset_recall_pkg::OFF_CONFIG, keep);
        wr(preset_recall_pkg::OFF_CMD, slot_cmd(4, 1'b0));
        repeat (8) @(posedge clk);
        check_word(active_config, keep);
        rd_chk(preset_recall_pkg::OFF_STATUS, bit_of(preset_recall_pkg::IRQ_EMPTY_BIT));
        check_word({31'h0, irq}, 32'h1);
        wr(preset_recall_pkg::OFF_STATUS, 32'h1f);
        rd_chk(preset_recall_pkg::OFF_STATUS, 32'h0);
        $display("Test empty recall done");
        wr(preset_recall_pkg::OFF_CMD, slot_cmd(6, 1'b1));
        rd_chk(preset_recall_pkg::OFF_VALID, 32'h0);
        for (int s = 1; s <= 5; s++)
        begin
            cfg_a[s] = $urandom();
            wr(preset_recall_pkg::OFF_CONFIG, cfg_a[s]);
            wr(preset_recall_pkg::OFF_CMD, slot_cmd(s, 1'b1));
            rd_chk(preset_recall_pkg::OFF_VALID, bit_of(s) - 32'h1);
        end
        $display("Test save done");
        for (int s = 5; s >= 1; s--)
        begin
            wr(preset_recall_pkg::OFF_CONFIG, keep);
            wr(preset_recall_pkg::OFF_CMD, slot_cmd(s, 1'b0));
            wait_cfg(cfg_a[s]);
            rd_chk(preset_recall_pkg::OFF_STATUS, bit_of(preset_recall_pkg::IRQ_DONE_BIT));
        end
        wr(preset_recall_pkg::OFF_MASK, 32'h0);
        repeat (3) @(posedge clk);
        check_word({31'h0, irq}, 32'h0);
        wr(preset_recall_pkg::OFF_STATUS, 32'h1f);
        $display("Test recall done");
        for (int i = 0; i < 3; i++)
        begin
            u_contacts.set_contact(i, 1'b1, 12);
            check_word({29'h0, lvl3, lvl2, lvl1}, 32'h7 ^ bit_of(i));
            u_contacts.set_contact(i, 1'b0, 12);
        end
        check_word(active_config, cfg_a[1]);
        rd_chk(preset_recall_pkg::OFF_STATUS, 32'h0);
        avs_byteenable <= 4'h1;
        wr(preset_recall_pkg::OFF_CONFIG, 32'h0);
        avs_byteenable <= 4'hf;
        rd_chk(preset_recall_pkg::OFF_CONFIG, cfg_a[1] & 32'hffff_ff00);
        $display("Test disabled inputs done");
        wr(preset_recall_pkg::OFF_ACTION, 32'h7);
        for (int i = 0; i < 3; i++)
        begin
            wr(preset_recall_pkg::OFF_CONFIG, keep);
            u_contacts.set_contact(i, 1'b1, 12);
            wait_cfg(cfg_a[i + 1]);
            rd_chk(preset_recall_pkg::OFF_STATUS, bit_of(i) | bit_of(preset_recall_pkg::IRQ_DONE_BIT));
            wr(preset_recall_pkg::OFF_STATUS, 32'h1f);
            wr(preset_recall_pkg::OFF_CONFIG, keep);
            u_contacts.set_contact(i, 1'b0, 12);
            check_word(active_config, keep);
            rd_chk(preset_recall_pkg::OFF_STATUS, 32'h0);
        end
        u_contacts.set_contact(2, 1'b1, 0);
        u_contacts.set_contact(0, 1'b1, 0);
        u_contacts.set_contact(1, 1'b1, 12);
        // Input three is served first, then one and two in order, so slot 2 ends up active.
        wait_cfg(cfg_a[2]);
        rd_chk(preset_recall_pkg::OFF_STATUS, 32'hf);
        $display("Test armed inputs done");
        tally_and_finish();
    end
endmodule : edge_triggered_preset_recall_tb_top

bind preset_recall preset_recall_properties u_props (.clk(clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .input_pin(input_pin),
    .input_one_level_report(input_one_level_report), .input_two_level_report(input_two_level_report),
    .input_three_level_report(input_three_level_report), .active_config(active_config), .irq(irq));

`default_nettype wire
